// file: rtl/rrs_fifo_level.sv
// Fill level and overrun tracking of the receive FIFO.
// Assumes push, pop and flush come from the FIFO logic on the same clock.
module rrs_fifo_level #(
   parameter int DEPTH = 64,
   parameter int CW    = 7
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   input  wire rrs_pkg::rrs_fifo_req_t i_req,
   output logic      [CW-1:0]     o_count,
   output logic                   o_overrun,
   output logic                   o_overrun_evt
);
   import rrs_pkg::*;

   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   typedef struct packed {
      logic [CW-1:0] count;
      logic          overrun;
      logic          evt;
   } rrs_fl_st_t;

   rrs_fl_st_t st;
   rrs_fl_st_t next_st;
   logic       take;
   logic       give;

   always_comb begin
      next_st = st;
      next_st.evt = 1'b0;
      // After an overrun nothing more is taken until a flush
      take = i_req.push && !st.overrun && (st.count != FULL || i_req.pop);
      give = i_req.pop && st.count != '0;
      if (i_req.flush) begin
         next_st.count   = '0;
         next_st.overrun = 1'b0;
      end else begin
         if (take && !give) begin
            next_st.count = st.count + CW'(1);
         end else if (give && !take) begin
            next_st.count = st.count - CW'(1);
         end
         if (i_req.push && !st.overrun && st.count == FULL && !i_req.pop) begin
            next_st.overrun = 1'b1;
            next_st.evt     = 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st <= '{count: CW'(COUNT_RST), overrun: 1'b0, evt: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign o_count       = st.count;
   assign o_overrun     = st.overrun;
   assign o_overrun_evt = st.evt;
endmodule

// file: rtl/rrs_flag_bank.sv
// Sticky event flags with write-one-to-clear, a mask and a level interrupt.
// Assumes set and clear strobes come from logic on the same clock.
module rrs_flag_bank #(
   parameter int N = 6
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rst,
   input  wire logic [N-1:0] i_set,
   input  wire logic         i_clr_wr,
   input  wire logic [N-1:0] i_clr_bits,
   input  wire logic         i_mask_wr,
   input  wire logic [N-1:0] i_mask_bits,
   output logic      [N-1:0] o_status,
   output logic      [N-1:0] o_mask,
   output logic              o_irq
);
   import rrs_pkg::*;

   typedef struct packed {
      logic [N-1:0] status;
      logic [N-1:0] mask;
      logic         irq;
   } rrs_fb_st_t;

   rrs_fb_st_t st;
   rrs_fb_st_t next_st;

   always_comb begin
      next_st = st;
      // A set in the clearing cycle survives
      if (i_clr_wr) begin
         next_st.status = st.status & ~i_clr_bits;
      end
      next_st.status = next_st.status | i_set;
      if (i_mask_wr) begin
         next_st.mask = i_mask_bits;
      end
      next_st.irq = |(next_st.status & next_st.mask);
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st <= '{status: N'(STATUS_RST), mask: N'(MASK_RST), irq: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign o_status = st.status;
   assign o_mask   = st.mask;
   assign o_irq    = st.irq;
endmodule

// file: rtl/rrs_pkg.sv
// Constants and carrier types for the receiver status readout.
// Assumes one core clock; every producer of these structs is on that clock.
package rrs_pkg;

   // Widths
   localparam int ADDR_W     = 6;
   localparam int DATA_W     = 8;
   localparam int STATE_W    = 5;
   localparam int FIFO_DEPTH = 64;
   localparam int CNT_W      = 7;
   localparam int N_EVT      = 6;

   // Register offsets
   localparam logic [ADDR_W-1:0] RADIO_STATE_ADDR   = 6'h35;
   localparam logic [ADDR_W-1:0] PACKET_STATUS_ADDR = 6'h38;
   localparam logic [ADDR_W-1:0] RX_FIFO_LEVEL_ADDR = 6'h3b;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR    = 6'h3c;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR      = 6'h3d;

   // State codes reported in radio_state
   localparam logic [STATE_W-1:0] SC_SLEEP            = 5'h00;
   localparam logic [STATE_W-1:0] SC_IDLE             = 5'h01;
   localparam logic [STATE_W-1:0] SC_CRYSTAL_OFF      = 5'h02;
   localparam logic [STATE_W-1:0] SC_MANUAL_CAL_OSC   = 5'h03;
   localparam logic [STATE_W-1:0] SC_MANUAL_CAL_REG   = 5'h04;
   localparam logic [STATE_W-1:0] SC_MANUAL_CAL       = 5'h05;
   localparam logic [STATE_W-1:0] SC_SYNTH_WAKE_OSC   = 5'h06;
   localparam logic [STATE_W-1:0] SC_SYNTH_WAKE_REG   = 5'h07;
   localparam logic [STATE_W-1:0] SC_CAL_BEGIN        = 5'h08;
   localparam logic [STATE_W-1:0] SC_BANDWIDTH_BOOST  = 5'h09;
   localparam logic [STATE_W-1:0] SC_SYNTH_LOCK       = 5'h0a;
   localparam logic [STATE_W-1:0] SC_IF_CONVERTER_ON  = 5'h0b;
   localparam logic [STATE_W-1:0] SC_CAL_FINISH       = 5'h0c;
   localparam logic [STATE_W-1:0] SC_RX               = 5'h0d;
   localparam logic [STATE_W-1:0] SC_RX_END           = 5'h0e;
   localparam logic [STATE_W-1:0] SC_RX_RESTART       = 5'h0f;
   localparam logic [STATE_W-1:0] SC_RSVD_A           = 5'h10;
   localparam logic [STATE_W-1:0] SC_RX_OVERRUN       = 5'h11;
   localparam logic [STATE_W-1:0] SC_RSVD_B           = 5'h12;

   // packet_status fields
   localparam int PS_CRC_OK_BIT  = 7;
   localparam int PS_CARRIER_BIT = 6;
   localparam int PS_FRAME_BIT   = 3;
   localparam int PS_GP_TWO_BIT  = 2;
   localparam int PS_GP_ZERO_BIT = 0;

   // rx_fifo_level fields
   localparam int RL_OVERRUN_BIT = 7;

   // Interrupt status / mask bit positions
   localparam int EV_CRC_OK   = 0;
   localparam int EV_SYNC     = 1;
   localparam int EV_PKT_END  = 2;
   localparam int EV_DISCARD  = 3;
   localparam int EV_OVERRUN  = 4;
   localparam int EV_CARRIER  = 5;

   // Reset values
   localparam logic [DATA_W-1:0]  RD_DATA_RST = 8'h00;
   localparam logic [STATE_W-1:0] CODE_RST    = 5'h00;
   localparam logic [N_EVT-1:0]   MASK_RST    = 6'h00;
   localparam logic [N_EVT-1:0]   STATUS_RST  = 6'h00;
   localparam logic [CNT_W-1:0]   COUNT_RST   = 7'h00;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } rrs_reg_req_t;

   typedef struct packed {
      logic crc_done;
      logic crc_match;
      logic carrier;
      logic sync_found;
      logic packet_end;
      logic packet_discard;
   } rrs_rx_evt_t;

   typedef struct packed {
      logic push;
      logic pop;
      logic flush;
   } rrs_fifo_req_t;

   typedef struct packed {
      logic two_pin;
      logic two_invert;
      logic zero_pin;
      logic zero_invert;
   } rrs_gp_lvl_t;

endpackage

// file: rtl/rrs_status.sv
// Status readout of the packet receiver: radio state, packet flags, FIFO
// level, plus sticky event flags with mask and one interrupt line.
// Assumes every input comes from logic on i_core_clk; the register port
// is a plain strobe port with read data one cycle after the read strobe.
module rrs_status #(
   parameter int FIFO_DEPTH = rrs_pkg::FIFO_DEPTH
) (
   input  wire logic                          i_core_clk,
   input  wire logic                          i_rst,
   input  wire rrs_pkg::rrs_reg_req_t         i_reg,
   input  wire logic [rrs_pkg::STATE_W-1:0]   i_state_code,
   input  wire rrs_pkg::rrs_rx_evt_t          i_rx_evt,
   input  wire rrs_pkg::rrs_fifo_req_t        i_fifo,
   input  wire rrs_pkg::rrs_gp_lvl_t          i_gp,
   output logic      [rrs_pkg::DATA_W-1:0]    o_rd_data,
   output logic                               o_irq
);
   import rrs_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0]  rd_data;
      logic [STATE_W-1:0] prev_code;
      logic               crc_ok;
      logic               carrier;
      logic               frame;
   } rrs_top_st_t;

   rrs_top_st_t st;
   rrs_top_st_t next_st;

   logic [CNT_W-1:0] fifo_count;
   logic             fifo_overrun;
   logic             overrun_evt;
   logic [N_EVT-1:0] evt_set;
   logic [N_EVT-1:0] irq_status;
   logic [N_EVT-1:0] irq_mask;
   logic             irq_flag;
   logic             status_clr_wr;
   logic             mask_wr;
   logic             gp_two_raw;
   logic             gp_zero_raw;
   logic             rx_entry;
   logic             idle_entry;
   logic             in_overrun;
   logic [DATA_W-1:0] state_word;
   logic [DATA_W-1:0] pkt_word;
   logic [DATA_W-1:0] level_word;

   // True for the codes in which receive mode is (re)started
   function automatic logic is_rx_start(input logic [STATE_W-1:0] code);
      return code == SC_RX || code == SC_RX_RESTART;
   endfunction

   // Codes the state machine may legally report
   function automatic logic is_legal_code(input logic [STATE_W-1:0] code);
      logic ok;
      ok = 1'b0;
      unique case (code)
         SC_SLEEP, SC_IDLE, SC_CRYSTAL_OFF: ok = 1'b1;
         SC_MANUAL_CAL_OSC, SC_MANUAL_CAL_REG, SC_MANUAL_CAL: ok = 1'b1;
         SC_SYNTH_WAKE_OSC, SC_SYNTH_WAKE_REG: ok = 1'b1;
         SC_CAL_BEGIN, SC_CAL_FINISH: ok = 1'b1;
         SC_BANDWIDTH_BOOST, SC_SYNTH_LOCK, SC_IF_CONVERTER_ON: ok = 1'b1;
         SC_RX, SC_RX_END, SC_RX_RESTART: ok = 1'b1;
         SC_RX_OVERRUN: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Event flags and interrupt line
   rrs_flag_bank #(
      .N (N_EVT)
   ) u_flags (
      .i_core_clk  (i_core_clk),
      .i_rst       (i_rst),
      .i_set       (evt_set),
      .i_clr_wr    (status_clr_wr),
      .i_clr_bits  (i_reg.wdata[N_EVT-1:0]),
      .i_mask_wr   (mask_wr),
      .i_mask_bits (i_reg.wdata[N_EVT-1:0]),
      .o_status    (irq_status),
      .o_mask      (irq_mask),
      .o_irq       (irq_flag)
   );

   // Receive FIFO fill level
   rrs_fifo_level #(
      .DEPTH (FIFO_DEPTH),
      .CW    (CNT_W)
   ) u_level (
      .i_core_clk    (i_core_clk),
      .i_rst         (i_rst),
      .i_req         (i_fifo),
      .o_count       (fifo_count),
      .o_overrun     (fifo_overrun),
      .o_overrun_evt (overrun_evt)
   );

   // Writes reach only the interrupt registers; status words are read-only
   assign status_clr_wr = i_reg.wr && i_reg.addr == IRQ_STATUS_ADDR;
   assign mask_wr       = i_reg.wr && i_reg.addr == IRQ_MASK_ADDR;

   // Undo the programmed inversion to get the level before the pin driver
   assign gp_two_raw  = i_gp.two_pin ^ i_gp.two_invert;
   assign gp_zero_raw = i_gp.zero_pin ^ i_gp.zero_invert;

   // Mode transitions seen on the state code
   assign rx_entry   = is_rx_start(i_state_code)
                       && (i_state_code != st.prev_code);
   assign idle_entry = i_state_code == SC_IDLE
                       && st.prev_code != SC_IDLE;
   assign in_overrun = i_state_code == SC_RX_OVERRUN;

   always_comb begin
      evt_set = '0;
      evt_set[EV_CRC_OK]  = i_rx_evt.crc_done && i_rx_evt.crc_match;
      evt_set[EV_SYNC]    = i_rx_evt.sync_found;
      evt_set[EV_PKT_END] = i_rx_evt.packet_end;
      evt_set[EV_DISCARD] = i_rx_evt.packet_discard;
      evt_set[EV_OVERRUN] = overrun_evt;
      evt_set[EV_CARRIER] = next_st.carrier && !st.carrier;
   end

   // Assembled read words
   always_comb begin
      state_word = '0;
      // Codes pass through unchanged, reserved ones included
      state_word[STATE_W-1:0] = i_state_code;
   end

   always_comb begin
      pkt_word = '0;
      pkt_word[PS_CRC_OK_BIT]  = st.crc_ok;
      pkt_word[PS_CARRIER_BIT] = st.carrier;
      pkt_word[PS_FRAME_BIT]   = st.frame;
      pkt_word[PS_GP_TWO_BIT]  = gp_two_raw;
      pkt_word[PS_GP_ZERO_BIT] = gp_zero_raw;
   end

   always_comb begin
      level_word = '0;
      level_word[CNT_W-1:0]      = fifo_count;
      level_word[RL_OVERRUN_BIT] = fifo_overrun;
   end

   always_comb begin
      next_st = st;
      next_st.prev_code = i_state_code;

      // CRC result; a fresh comparison beats the mode-entry clear
      if (i_rx_evt.crc_done) begin
         next_st.crc_ok = i_rx_evt.crc_match;
      end else if (rx_entry) begin
         next_st.crc_ok = 1'b0;
      end

      // Carrier sense follows the detector and is held clear in idle
      if (idle_entry || i_state_code == SC_IDLE) begin
         next_st.carrier = 1'b0;
      end else begin
         next_st.carrier = i_rx_evt.carrier;
      end

      // Frame delimiter: ends on packet end, discard or overrun
      if (i_rx_evt.packet_end || i_rx_evt.packet_discard || in_overrun) begin
         next_st.frame = 1'b0;
      end
      if (i_rx_evt.sync_found && !in_overrun) begin
         next_st.frame = 1'b1;
      end

      // Read data stand for one cycle only; reading changes no state
      next_st.rd_data = '0;
      if (i_reg.rd) begin
         unique case (i_reg.addr)
            RADIO_STATE_ADDR:   next_st.rd_data = state_word;
            PACKET_STATUS_ADDR: next_st.rd_data = pkt_word;
            RX_FIFO_LEVEL_ADDR: next_st.rd_data = level_word;
            IRQ_STATUS_ADDR: begin
               next_st.rd_data[N_EVT-1:0] = irq_status;
            end
            IRQ_MASK_ADDR: begin
               next_st.rd_data[N_EVT-1:0] = irq_mask;
            end
            default: next_st.rd_data = '0;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st <= '{rd_data:   RD_DATA_RST,
                 prev_code: CODE_RST,
                 crc_ok:    1'b0,
                 carrier:   1'b0,
                 frame:     1'b0};
      end else begin
         st <= next_st;
      end
   end

   // Illegal codes are passed on as they come; this flag is kept for debug
   logic code_legal;
   assign code_legal = is_legal_code(i_state_code);

   assign o_rd_data = st.rd_data;
   assign o_irq     = irq_flag;
endmodule

// file: verification/rrs_host_model.sv
// Host side of the status port: single-cycle write and read strobes.
// Assumes read data stand only in the cycle after the read strobe.
module rrs_host_model (
   input  wire logic                       i_core_clk,
   input  wire logic [rrs_pkg::DATA_W-1:0] i_rd_data,
   output rrs_pkg::rrs_reg_req_t           o_reg
);
   timeunit 1ns;
   timeprecision 1ps;
   import rrs_pkg::*;
   initial o_reg = '0;
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge i_core_clk);
      o_reg <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge i_core_clk);
      o_reg.wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a,
                     output logic [DATA_W-1:0] v);
      @(posedge i_core_clk);
      o_reg <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_core_clk);
      o_reg.rd <= 1'b0;
      #1 v = i_rd_data;
   endtask
endmodule

// file: verification/rrs_status_assertions.sv
// Checker for the receiver status readout, bound to the top module.
// Assumes one clock domain and the strobe register port of the design.
module rrs_status_checker #(
   parameter int FIFO_DEPTH = 64
) (
   input  wire logic                        i_core_clk,
   input  wire logic                        i_rst,
   input  wire rrs_pkg::rrs_reg_req_t       i_reg,
   input  wire logic [rrs_pkg::STATE_W-1:0] i_state_code,
   input  wire rrs_pkg::rrs_rx_evt_t        i_rx_evt,
   input  wire rrs_pkg::rrs_fifo_req_t      i_fifo,
   input  wire rrs_pkg::rrs_gp_lvl_t        i_gp,
   input  wire logic [rrs_pkg::DATA_W-1:0]  o_rd_data,
   input  wire logic                        o_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   import rrs_pkg::*;
   logic rd_st;
   logic rd_ps;
   logic rd_lv;
   logic wr_mask0;
   assign rd_st = i_reg.rd && i_reg.addr == RADIO_STATE_ADDR;
   assign rd_ps = i_reg.rd && i_reg.addr == PACKET_STATUS_ADDR;
   assign rd_lv = i_reg.rd && i_reg.addr == RX_FIFO_LEVEL_ADDR;
   assign wr_mask0 = i_reg.wr && i_reg.addr == IRQ_MASK_ADDR
                     && i_reg.wdata == 8'h00;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   a_state_code_read: assert property (
      rd_st |=> o_rd_data == {3'b000, $past(i_state_code)})
      else $error("state code read back wrong");
   a_gp_two_raw: assert property (
      rd_ps |=> o_rd_data[2] == ($past(i_gp.two_pin) ^ $past(i_gp.two_invert)))
      else $error("output two bit wrong");
   a_gp_zero_raw: assert property (
      rd_ps |=> o_rd_data[0] == ($past(i_gp.zero_pin)
                                 ^ $past(i_gp.zero_invert))
                && o_rd_data[1] == 1'b0)
      else $error("output zero bit or bit 1 wrong");
   a_crc_entry_clear: assert property (
      (i_state_code == SC_RX && $past(i_state_code) != SC_RX
       && !i_rx_evt.crc_done) ##1 rd_ps |=> !o_rd_data[PS_CRC_OK_BIT])
      else $error("crc flag survived receive entry");
   a_idle_carrier_low: assert property (
      rd_ps && i_state_code == SC_IDLE && $past(i_state_code) == SC_IDLE
      |=> !o_rd_data[PS_CARRIER_BIT])
      else $error("carrier flag set in idle");
   a_frame_end_drop: assert property (
      (i_rx_evt.packet_end && !i_rx_evt.sync_found)
      ##1 !i_rx_evt.sync_found ##1 rd_ps
      |=> !o_rd_data[PS_FRAME_BIT])
      else $error("frame flag kept after packet end");
   a_frame_overrun_drop: assert property (
      i_state_code == SC_RX_OVERRUN ##1 rd_ps |=> !o_rd_data[PS_FRAME_BIT])
      else $error("frame flag kept in overrun state");
   a_flush_level_zero: assert property (
      (i_fifo.flush && !i_fifo.push) ##1 !i_fifo.push ##1 rd_lv
      |=> o_rd_data == 8'h00)
      else $error("level not zero after flush");
   a_level_bound: assert property (
      rd_lv |=> int'(o_rd_data[6:0]) <= FIFO_DEPTH)
      else $error("level above depth");
   a_read_data_idle: assert property (
      !i_reg.rd |=> o_rd_data == 8'h00)
      else $error("read data without read strobe");
   a_irq_mask_off: assert property (
      wr_mask0 ##1 !i_reg.wr |=> !o_irq)
      else $error("interrupt high with zero mask");

   c_state_read: cover property (rd_st);
   c_irq_rise: cover property ($rose(o_irq));
   c_flush: cover property (i_fifo.flush);
endmodule

bind rrs_status rrs_status_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_checker (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg(i_reg),
   .i_state_code(i_state_code), .i_rx_evt(i_rx_evt), .i_fifo(i_fifo),
   .i_gp(i_gp), .o_rd_data(o_rd_data), .o_irq(o_irq));

// file: verification/rrs_status_test.sv
// Self-checking bench of the receiver status readout.
// Assumes the host model on the register port and a 25 MHz core clock.
module rrs_status_test;
   timeunit 1ns;
   timeprecision 1ps;
   import rrs_pkg::*;
   logic               i_core_clk = 1'b0;
   logic               i_rst = 1'b1;
   rrs_reg_req_t       req;
   logic [STATE_W-1:0] code = SC_IDLE;
   logic [5:0]         pulse = '0;
   logic               car = 1'b0;
   logic [2:0]         ff = '0;
   rrs_gp_lvl_t        gp = '0;
   rrs_rx_evt_t        rx;
   logic [DATA_W-1:0]  rd_data;
   logic               irq;
   int                 fail_count = 0;
   int                 checked = 0;

   initial forever #20 i_core_clk = ~i_core_clk;
   assign rx = rrs_rx_evt_t'(pulse | {2'b00, car, 3'b000});

   rrs_host_model host (.i_core_clk(i_core_clk), .i_rd_data(rd_data),
                        .o_reg(req));
   rrs_status dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg(req),
      .i_state_code(code), .i_rx_evt(rx), .i_fifo(rrs_fifo_req_t'(ff)),
      .i_gp(gp), .o_rd_data(rd_data), .o_irq(irq));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host.rd(a, v);
      check(v, exp);
   endtask
   // One-cycle event and FIFO pulses
   task automatic step(input logic [5:0] p, input logic [2:0] f);
      @(posedge i_core_clk);
      pulse <= p;
      ff <= f;
      @(posedge i_core_clk);
      pulse <= '0;
      ff <= '0;
   endtask
   task automatic set_code(input logic [STATE_W-1:0] c);
      @(posedge i_core_clk);
      code <= c;
   endtask
   task automatic complete_run();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic t_state_codes();
      for (int c = 0; c < 19; c++) begin
         set_code(c[4:0]);
         rdc(RADIO_STATE_ADDR, {3'b000, c[4:0]});
      end
      host.wr(RADIO_STATE_ADDR, 8'hff);
      rdc(RADIO_STATE_ADDR, 8'h12);
      rdc(6'h20, 8'h00);
   endtask
   task automatic t_crc();
      set_code(SC_RX);
      step(6'h30, 3'h0);
      rdc(PACKET_STATUS_ADDR, 8'h80);
      rdc(PACKET_STATUS_ADDR, 8'h80);
      set_code(SC_RX_END);
      rdc(PACKET_STATUS_ADDR, 8'h80);
      set_code(SC_RX);
      rdc(PACKET_STATUS_ADDR, 8'h00);
      step(6'h30, 3'h0);
      set_code(SC_RX_RESTART);
      rdc(PACKET_STATUS_ADDR, 8'h00);
      step(6'h30, 3'h0);
      rdc(PACKET_STATUS_ADDR, 8'h80);
      step(6'h20, 3'h0);
      rdc(PACKET_STATUS_ADDR, 8'h00);
   endtask
   task automatic t_carrier();
      set_code(SC_RX);
      car <= 1'b1;
      rdc(PACKET_STATUS_ADDR, 8'h40);
      set_code(SC_IDLE);
      rdc(PACKET_STATUS_ADDR, 8'h00);
      set_code(SC_RX);
      rdc(PACKET_STATUS_ADDR, 8'h40);
      car <= 1'b0;
   endtask
   task automatic t_frame();
      step(6'h04, 3'h0);
      rdc(PACKET_STATUS_ADDR, 8'h08);
      step(6'h02, 3'h0);
      rdc(PACKET_STATUS_ADDR, 8'h00);
      step(6'h04, 3'h0);
      step(6'h01, 3'h0);
      rdc(PACKET_STATUS_ADDR, 8'h00);
      step(6'h04, 3'h0);
      set_code(SC_RX_OVERRUN);
      rdc(PACKET_STATUS_ADDR, 8'h00);
      step(6'h04, 3'h0);
      rdc(PACKET_STATUS_ADDR, 8'h00);
      set_code(SC_RX);
   endtask
   task automatic t_gp();
      for (int i = 0; i < 16; i++) begin
         @(posedge i_core_clk);
         gp <= rrs_gp_lvl_t'(i[3:0]);
         rdc(PACKET_STATUS_ADDR,
             {5'b00000, i[3] ^ i[2], 1'b0, i[1] ^ i[0]});
      end
   endtask
   task automatic t_fifo_irq();
      host.wr(IRQ_STATUS_ADDR, 8'h3f);
      repeat (64) step(6'h00, 3'h4);
      rdc(RX_FIFO_LEVEL_ADDR, 8'h40);
      step(6'h00, 3'h4);
      rdc(RX_FIFO_LEVEL_ADDR, 8'hc0);
      rdc(IRQ_STATUS_ADDR, 8'h10);
      rdc(IRQ_STATUS_ADDR, 8'h10);
      check({7'h00, irq}, 8'h00);
      host.wr(IRQ_MASK_ADDR, 8'h10);
      rdc(IRQ_MASK_ADDR, 8'h10);
      check({7'h00, irq}, 8'h01);
      host.wr(IRQ_STATUS_ADDR, 8'h10);
      rdc(IRQ_STATUS_ADDR, 8'h00);
      check({7'h00, irq}, 8'h00);
      host.wr(RX_FIFO_LEVEL_ADDR, 8'h00);
      rdc(RX_FIFO_LEVEL_ADDR, 8'hc0);
      step(6'h00, 3'h1);
      rdc(RX_FIFO_LEVEL_ADDR, 8'h00);
      step(6'h00, 3'h4);
      step(6'h00, 3'h4);
      step(6'h00, 3'h2);
      rdc(RX_FIFO_LEVEL_ADDR, 8'h01);
      step(6'h00, 3'h2);
      step(6'h00, 3'h2);
      rdc(RX_FIFO_LEVEL_ADDR, 8'h00);
      host.wr(IRQ_MASK_ADDR, 8'h00);
      step(6'h04, 3'h0);
      rdc(IRQ_STATUS_ADDR, 8'h02);
      check({7'h00, irq}, 8'h00);
   endtask

   initial begin
      repeat (6) @(posedge i_core_clk);
      i_rst <= 1'b0;
      t_state_codes();
      t_crc();
      t_carrier();
      t_frame();
      t_gp();
      t_fifo_irq();
      complete_run();
   end
   initial begin
      repeat (3000) @(posedge i_core_clk);
      fail_count++;
      complete_run();
   end
endmodule
